// *** src/brw_defines.vh ***
`ifndef BRW_DEFINES_VH
`define BRW_DEFINES_VH
// register indices; byte address is four times the index
`define BRW_IDX_MODE_CTRL    8'h00
`define BRW_IDX_THRESH_LVL   8'h01
`define BRW_IDX_WARN_LVL     8'h08
`define BRW_IDX_WARN_ICTRL   8'h09
`define BRW_IDX_WARN_FLAGS   8'h0A
`define BRW_IDX_WARN_STAT    8'h0B
`define BRW_ADDR_LSB         2
`define BRW_ADDR_MSB         9
// mode control fields
`define BRW_RATE_BIT         4
`define BRW_ACT_HI           3
`define BRW_ACT_LO           2
`define BRW_SLP_HI           1
`define BRW_SLP_LO           0
// interrupt control fields
`define BRW_IE_BIT           0
`define BRW_TRIG_HI          2
`define BRW_TRIG_LO          1
`define BRW_FLAG_BIT         0
`define BRW_STAT_BIT         0
// warning offset and threshold fields
`define BRW_OFS_HI           1
`define BRW_OFS_LO           0
`define BRW_THR_HI           2
`define BRW_THR_LO           0
// detector modes
`define BRW_MODE_OFF         2'h0
`define BRW_MODE_CONT        2'h1
`define BRW_MODE_SAMPLED     2'h2
`define BRW_MODE_WAKE_GATED  2'h3
// warning trigger choices
`define BRW_TRIG_BELOW       2'h0
`define BRW_TRIG_ABOVE       2'h1
`define BRW_TRIG_CROSS       2'h2
// reset values
`define BRW_RST_BYTE         8'h00
`define BRW_RST_TRIG         2'h0
`define BRW_RST_OFFSET       2'h0
// unlock window in instructions
`define BRW_UNLOCK_INSTR     3'h4
`define BRW_UNLOCK_ZERO      3'h0
`define BRW_UNLOCK_ONE       3'h1
// timing: clock in MHz, sample periods in microseconds
`define BRW_CLK_MHZ          24'd250
`define BRW_PER_FAST_US      24'd1000
`define BRW_PER_SLOW_US      24'd8000
// ahb encodings
`define BRW_HTRANS_NSEQ_BIT  1
`define BRW_HRESP_OKAY       1'b0
`define BRW_ZERO_WORD        32'h00000000
`define BRW_CNT_W            24
`endif

// *** src/brw_sample_timer.v ***
`timescale 1ns/1ps
`default_nettype none
`include "brw_defines.vh"
// free-running tick source for sampled detector operation
module brw_sample_timer #(
    parameter [`BRW_CNT_W-1:0] FAST_CYCLES = 24'd250000,
    parameter [`BRW_CNT_W-1:0] SLOW_CYCLES = 24'd2000000
) (
    input  wire                  clock,
    input  wire                  sys_rst,
    input  wire                  clk_en,
    input  wire                  run,
    input  wire                  slow_sel,
    output reg                   tick_q
);
    reg  [`BRW_CNT_W-1:0] count_q;
    wire [`BRW_CNT_W-1:0] last;

    assign last = slow_sel ? (SLOW_CYCLES - 24'd1) : (FAST_CYCLES - 24'd1);

    // restart on every run so the first sample follows a full period
    always @(posedge clock) begin
        if (sys_rst) begin
            count_q <= {`BRW_CNT_W{1'b0}};
            tick_q  <= 1'b0;
        end else if (clk_en) begin
            tick_q <= 1'b0;
            if (!run) begin
                count_q <= {`BRW_CNT_W{1'b0}};
            end else if (count_q >= last) begin
                count_q <= {`BRW_CNT_W{1'b0}};
                tick_q  <= 1'b1;
            end else begin
                count_q <= count_q + 24'd1;
            end
        end
    end
endmodule // brw_sample_timer
`default_nettype wire

// *** src/brw_top.v ***
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "brw_defines.vh"
// Operation
// - rate bit clear samples at 1 kHz, set samples at 125 Hz.
// - rate, active mode and sleep mode reset from fuse inputs.
// - rate bit is read-only and needs no unlock.
// - read-only active mode sets detector mode when awake.
// - active mode 3 holds execution after wake until detector runs.
// - writable sleep mode sets detector mode in deep sleep.
// - read-only fuse-loaded threshold code selects brown-out level.
// - offset code places warning level 5, 15 or 25 percent above.
// - trigger field picks fall, rise or either crossing.
// - interrupt enable bit gates the warning interrupt.
// - matching monitor event sets the warning flag.
// - flag only sets while detector and interrupt enable are on; a clear write works anytime except against a same-cycle set.
// - status reads 1 below warning level, 0 above.
// - deep sleep uses sleep mode, waking returns to active mode.
// - sleep mode write lands only within four instructions of unlock.
// - interrupt asserted while enable and flag both set.
// - monitor follows detector mode, off and sampled alike.
module brw_top #(
    parameter [`BRW_CNT_W-1:0] FAST_CYCLES =
        `BRW_CLK_MHZ * `BRW_PER_FAST_US,
    parameter [`BRW_CNT_W-1:0] SLOW_CYCLES =
        `BRW_CLK_MHZ * `BRW_PER_SLOW_US
) (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        clk_en,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg         hreadyout,
    output reg  [31:0] hrdata,
    output reg         hresp,
    input  wire        fuse_reload,
    input  wire        fuse_sample_rate,
    input  wire [1:0]  fuse_active_mode,
    input  wire [1:0]  fuse_sleep_mode,
    input  wire [2:0]  fuse_threshold,
    input  wire        unlock_key_written,
    input  wire        instr_retired,
    input  wire        deep_sleep,
    input  wire        detector_running,
    input  wire        warn_below_cmp,
    output reg  [1:0]  detector_mode_q,
    output reg  [2:0]  threshold_out_q,
    output reg  [1:0]  warn_offset_out_q,
    output reg         monitor_enable_q,
    output reg         sample_strobe_q,
    output reg         exec_hold_q,
    output reg         warn_irq_q
);
    ////////////////////////////////////////////////////////////////////
    // configuration state
    reg        sample_rate_select_q;
    reg [1:0]  active_mode_q;
    reg [1:0]  sleep_mode_q;
    reg [2:0]  brownout_threshold_sel_q;
    reg [1:0]  warning_offset_sel_q;
    reg [1:0]  warning_trigger_sel_q;
    reg        warning_irq_enable_q;
    reg        warning_irq_flag_q;
    reg        warning_below_status_q;
    reg        below_prev_q;
    reg        prev_valid_q;
    reg        deep_sleep_q;
    reg [2:0]  unlock_cnt_q;

    // bus state
    reg        dph_valid_q;
    reg        dph_write_q;
    reg [7:0]  dph_idx_q;
    reg        rd_pend_q;

    wire       addr_phase;
    wire [7:0] addr_idx;
    wire       wr_now;
    wire [7:0] wdat;
    wire       sample_tick;
    wire [1:0] mode_d;
    wire       det_on;
    wire       take_sample;
    wire       evt_match;
    wire       flag_clr;
    wire       unlocked;
    wire       wake_edge;
    reg  [7:0] rd_byte;
    reg        evt_match_r;

    // nonseq and seq are both decoded via htrans bit 1; the master issues singles, never seq
    // a narrow address window is decoded, so upper address bits alias
    assign addr_phase = hsel & hready & htrans[`BRW_HTRANS_NSEQ_BIT];
    assign addr_idx   = haddr[`BRW_ADDR_MSB:`BRW_ADDR_LSB];
    assign wr_now     = dph_valid_q & dph_write_q;
    // registers are eight bits wide; upper write data is ignored
    assign wdat       = hwdata[7:0];

    ////////////////////////////////////////////////////////////////////
    // effective detector mode
    // sleep code 3 is reserved; treated as off so nothing half-runs
    assign mode_d = deep_sleep ?
        ((sleep_mode_q == `BRW_MODE_WAKE_GATED) ? `BRW_MODE_OFF
                                                : sleep_mode_q)
        : active_mode_q;
    // on/off is judged from the registered mode the analog side sees
    assign det_on = (detector_mode_q != `BRW_MODE_OFF);

    // timer only runs in sampled mode, so its phase restarts each entry
    brw_sample_timer #(
        .FAST_CYCLES (FAST_CYCLES),
        .SLOW_CYCLES (SLOW_CYCLES)
    ) u_timer (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .run      (detector_mode_q == `BRW_MODE_SAMPLED),
        .slow_sel (sample_rate_select_q),
        .tick_q   (sample_tick)
    );

    // monitor samples each cycle in continuous modes, on ticks if sampled
    assign take_sample = det_on & warning_irq_enable_q &
        ((detector_mode_q != `BRW_MODE_SAMPLED) | sample_tick);

    // history holds the last sample, so an edge needs two samples
    always @* begin
        case (warning_trigger_sel_q)
            `BRW_TRIG_BELOW: evt_match_r = ~below_prev_q & warn_below_cmp;
            `BRW_TRIG_ABOVE: evt_match_r = below_prev_q & ~warn_below_cmp;
            `BRW_TRIG_CROSS: evt_match_r = below_prev_q ^ warn_below_cmp;
            default:         evt_match_r = 1'b0;
        endcase
    end
    assign evt_match = take_sample & prev_valid_q & evt_match_r;

    // clear acts at the data phase edge of a write to the flag word
    assign flag_clr = wr_now & (dph_idx_q == `BRW_IDX_WARN_FLAGS) &
                      wdat[`BRW_FLAG_BIT];
    assign unlocked  = (unlock_cnt_q != `BRW_UNLOCK_ZERO);
    // wake edge is seen in the same cycle that sleep ends at the pin
    assign wake_edge = deep_sleep_q & ~deep_sleep;

    ////////////////////////////////////////////////////////////////////
    // register file and monitor
    always @(posedge clock) begin
        if (sys_rst) begin
            sample_rate_select_q     <= fuse_sample_rate;
            active_mode_q            <= fuse_active_mode;
            sleep_mode_q             <= fuse_sleep_mode;
            // threshold copy is fuse loaded too, never written by software
            brownout_threshold_sel_q <= fuse_threshold;
            warning_offset_sel_q     <= `BRW_RST_OFFSET;
            warning_trigger_sel_q    <= `BRW_RST_TRIG;
            warning_irq_enable_q     <= 1'b0;
            warning_irq_flag_q       <= 1'b0;
            warning_below_status_q   <= 1'b0;
            below_prev_q             <= 1'b0;
            prev_valid_q             <= 1'b0;
            unlock_cnt_q             <= `BRW_UNLOCK_ZERO;
        end else if (clk_en) begin
            // a fuse reload wins over a software write in the same cycle
            if (fuse_reload) begin
                sample_rate_select_q     <= fuse_sample_rate;
                active_mode_q            <= fuse_active_mode;
                brownout_threshold_sel_q <= fuse_threshold;
            end
            // unlock window counts down one per retired instruction
            // a new key pulse always reopens the full window
            if (unlock_key_written)
                unlock_cnt_q <= `BRW_UNLOCK_INSTR;
            else if (unlocked & instr_retired)
                unlock_cnt_q <= unlock_cnt_q - `BRW_UNLOCK_ONE;
            if (fuse_reload)
                sleep_mode_q <= fuse_sleep_mode;
            else if (wr_now & unlocked &
                     (dph_idx_q == `BRW_IDX_MODE_CTRL))
                sleep_mode_q <= wdat[`BRW_SLP_HI:`BRW_SLP_LO];
            if (wr_now & (dph_idx_q == `BRW_IDX_WARN_LVL))
                // reserved offset codes are kept; the analog side decides
                warning_offset_sel_q <=
                    wdat[`BRW_OFS_HI:`BRW_OFS_LO];
            if (wr_now & (dph_idx_q == `BRW_IDX_WARN_ICTRL)) begin
                warning_trigger_sel_q <=
                    wdat[`BRW_TRIG_HI:`BRW_TRIG_LO];
                warning_irq_enable_q  <= wdat[`BRW_IE_BIT];
            end
            // set beats a same-cycle clear
            if (evt_match & det_on)
                warning_irq_flag_q <= 1'b1;
            else if (flag_clr)
                warning_irq_flag_q <= 1'b0;
            if (take_sample) begin
                warning_below_status_q <= warn_below_cmp;
                below_prev_q           <= warn_below_cmp;
                prev_valid_q           <= 1'b1;
            end else if (!det_on || !warning_irq_enable_q) begin
                // stale history must not fake a crossing on re-enable
                prev_valid_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs toward the analog side and the sleep controller
    always @(posedge clock) begin
        if (sys_rst) begin
            detector_mode_q   <= `BRW_MODE_OFF;
            threshold_out_q   <= fuse_threshold;
            warn_offset_out_q <= `BRW_RST_OFFSET;
            monitor_enable_q  <= 1'b0;
            sample_strobe_q   <= 1'b0;
            exec_hold_q       <= 1'b0;
            warn_irq_q        <= 1'b0;
            deep_sleep_q      <= 1'b0;
        end else if (clk_en) begin
            deep_sleep_q      <= deep_sleep;
            detector_mode_q   <= mode_d;
            threshold_out_q   <= brownout_threshold_sel_q;
            warn_offset_out_q <= warning_offset_sel_q;
            monitor_enable_q  <= det_on & warning_irq_enable_q;
            // strobe lags the tick one cycle so it comes from a flop
            sample_strobe_q   <= sample_tick;
            // level request, stands until the flag or the enable bit is cleared
            warn_irq_q <= warning_irq_enable_q &
                          warning_irq_flag_q;
            // a wake edge wins: running seen from before sleep is stale
            if (wake_edge &
                (active_mode_q == `BRW_MODE_WAKE_GATED))
                exec_hold_q <= 1'b1;
            else if (detector_running)
                exec_hold_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux; unused bits and unmapped words read zero
    always @* begin
        rd_byte = `BRW_RST_BYTE;
        case (dph_idx_q)
            `BRW_IDX_MODE_CTRL: begin
                rd_byte[`BRW_RATE_BIT] = sample_rate_select_q;
                rd_byte[`BRW_ACT_HI:`BRW_ACT_LO] = active_mode_q;
                rd_byte[`BRW_SLP_HI:`BRW_SLP_LO] = sleep_mode_q;
            end
            `BRW_IDX_THRESH_LVL:
                rd_byte[`BRW_THR_HI:`BRW_THR_LO] = brownout_threshold_sel_q;
            `BRW_IDX_WARN_LVL:
                rd_byte[`BRW_OFS_HI:`BRW_OFS_LO] = warning_offset_sel_q;
            `BRW_IDX_WARN_ICTRL: begin
                rd_byte[`BRW_TRIG_HI:`BRW_TRIG_LO] = warning_trigger_sel_q;
                rd_byte[`BRW_IE_BIT] = warning_irq_enable_q;
            end
            `BRW_IDX_WARN_FLAGS:
                rd_byte[`BRW_FLAG_BIT] = warning_irq_flag_q;
            `BRW_IDX_WARN_STAT:
                rd_byte[`BRW_STAT_BIT] = warning_below_status_q;
            default:
                rd_byte = `BRW_RST_BYTE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // ahb-lite slave: writes zero wait, reads one wait state
    // the wait lets a read see a write made in the cycle before it
    // hresp never leaves okay: no access here can fail
    // clk_en low freezes the bus too; keep it high during an access
    always @(posedge clock) begin
        if (sys_rst) begin
            dph_valid_q <= 1'b0;
            dph_write_q <= 1'b0;
            dph_idx_q   <= `BRW_RST_BYTE;
            rd_pend_q   <= 1'b0;
            hreadyout   <= 1'b1;
            hrdata      <= `BRW_ZERO_WORD;
            hresp       <= `BRW_HRESP_OKAY;
        end else if (clk_en) begin
            hresp <= `BRW_HRESP_OKAY;
            if (addr_phase) begin
                dph_valid_q <= 1'b1;
                dph_write_q <= hwrite;
                dph_idx_q   <= addr_idx;
                rd_pend_q   <= ~hwrite;
                hreadyout   <= hwrite;
            end else if (rd_pend_q) begin
                rd_pend_q   <= 1'b0;
                hrdata      <= {24'h000000, rd_byte};
                hreadyout   <= 1'b1;
            end else if (hreadyout) begin
                dph_valid_q <= 1'b0;
                dph_write_q <= 1'b0;
            end
        end
    end
endmodule // brw_top
`default_nettype wire

// *** tb/brw_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module brw_far_model #(
    parameter int RUN_DELAY = 8
) (
    input  wire logic clock,
    input  wire logic deep_sleep,
    input  wire logic supply_below,
    output var  logic detector_running,
    output var  logic warn_below_cmp
);
    int wake_cnt = 0;
    // the detector needs time to settle after every wake-up
    always @(posedge clock) begin
        warn_below_cmp <= supply_below;
        if (deep_sleep)
            wake_cnt <= RUN_DELAY;
        else if (wake_cnt != 0)
            wake_cnt <= wake_cnt - 1;
    end
    always_comb detector_running = !deep_sleep && wake_cnt == 0;
endmodule // brw_far_model
`default_nettype wire

// *** tb/brw_top_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "brw_defines.vh"
module brw_top_sva (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        fuse_reload,
    input wire logic [1:0]  fuse_active_mode,
    input wire logic [2:0]  fuse_threshold,
    input wire logic        deep_sleep,
    input wire logic        detector_running,
    input wire logic [1:0]  detector_mode_q,
    input wire logic [2:0]  threshold_out_q,
    input wire logic        monitor_enable_q,
    input wire logic        sample_strobe_q,
    input wire logic        exec_hold_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic [2:0] reload_q;
    logic       quiet;
    // fuse copies lag a reload or a reset by a few cycles
    always_ff @(posedge clock)
        reload_q <= sys_rst ? 3'h7 : {reload_q[1:0], fuse_reload};
    assign quiet = !fuse_reload && reload_q == 3'h0;
    ////////////////////////////////////////////////////////////////////////
    chk_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    chk_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    chk_thresh_fuse: assert property (quiet
        |-> threshold_out_q == fuse_threshold) else $error("threshold bad");
    chk_mode_awake: assert property (quiet && !deep_sleep
        && !$past(deep_sleep) && !$past(deep_sleep, 2)
        |-> detector_mode_q == fuse_active_mode) else $error("awake mode");
    chk_hold_set: assert property (quiet && $fell(deep_sleep)
        && fuse_active_mode == `BRW_MODE_WAKE_GATED && !detector_running
        |-> ##[1:2] exec_hold_q) else $error("no hold at wake");
    chk_hold_clear: assert property (exec_hold_q && detector_running
        |=> !exec_hold_q) else $error("hold kept");
    chk_strobe_mode: assert property (sample_strobe_q
        && $stable(detector_mode_q)
        |-> detector_mode_q == `BRW_MODE_SAMPLED) else $error("strobe mode");
    chk_strobe_pulse: assert property (sample_strobe_q
        |=> !sample_strobe_q) else $error("strobe too long");
    chk_monitor_off: assert property (detector_mode_q == `BRW_MODE_OFF
        && $stable(detector_mode_q) |-> !monitor_enable_q)
        else $error("monitor on while off");
    cover property (exec_hold_q);
    cover property (sample_strobe_q);
    cover property (monitor_enable_q);
endmodule // brw_top_sva
bind brw_top brw_top_sva brw_top_sva_inst (.*);
`default_nettype wire

// *** tb/brw_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "brw_defines.vh"
module brw_top_test;
    localparam logic [7:0] r_mode = `BRW_IDX_MODE_CTRL;
    localparam logic [7:0] r_thr = `BRW_IDX_THRESH_LVL;
    localparam logic [7:0] r_lvl = `BRW_IDX_WARN_LVL;
    localparam logic [7:0] r_ict = `BRW_IDX_WARN_ICTRL;
    localparam logic [7:0] r_flg = `BRW_IDX_WARN_FLAGS;
    localparam logic [7:0] r_sta = `BRW_IDX_WARN_STAT;
    logic clock = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, hsel = 1'b0;
    logic hwrite = 1'b0, fuse_reload = 1'b0, fuse_sample_rate = 1'b1;
    logic [1:0] htrans = 2'h0, fuse_active_mode = 2'h1, fuse_sleep_mode = 2'h1;
    logic [2:0] hsize = 3'h2, fuse_threshold = 3'h3;
    logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, rd;
    logic unlock_key_written = 1'b0, instr_retired = 1'b0;
    logic deep_sleep = 1'b0, supply_below = 1'b0;
    logic hreadyout, hresp, detector_running, warn_below_cmp, exec_hold_q;
    logic warn_irq_q, monitor_enable_q, sample_strobe_q;
    logic [31:0] hrdata;
    logic [1:0]  detector_mode_q, warn_offset_out_q;
    logic [2:0]  threshold_out_q;
    wire logic   hready;
    int          errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    assign hready = hreadyout;
    brw_top #(.FAST_CYCLES(24'd8), .SLOW_CYCLES(24'd32)) brw_top_inst (.*);
    brw_far_model brw_far_model_inst (.*);
    initial forever #2 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("errors=%0d checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task ticks(input int n);
        repeat (n) @(posedge clock);
    endtask
    // 0: unlock key, 1: retired instruction, other: fuse reload
    task pulse(input int which);
        case (which)
            0: unlock_key_written <= 1'b1;
            1: instr_retired <= 1'b1;
            default: fuse_reload <= 1'b1;
        endcase
        @(posedge clock);
        unlock_key_written <= 1'b0;
        instr_retired <= 1'b0;
        fuse_reload <= 1'b0;
        @(posedge clock);
    endtask
    // negedge view equals what the next rising edge samples
    task wait_ready;
        @(negedge clock);
        while (hreadyout !== 1'b1) @(negedge clock);
        rd = hrdata;
        @(posedge clock);
    endtask
    task xfer(input logic [7:0] idx, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {22'h000000, idx, 2'h0};
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask
    task wr(input logic [7:0] idx, input logic [31:0] d);
        xfer(idx, 1'b1, d);
    endtask
    task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        xfer(idx, 1'b0, 32'h00000000);
        check(rd, exp);
        check(hresp, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_reset_regs;
        rd_chk(r_mode, 32'h00000015);
        rd_chk(r_thr, 32'h00000003);
        rd_chk(r_flg, 32'h00000000);
        wr(r_mode, 32'hFFFFFFFF);
        rd_chk(r_mode, 32'h00000015);
        wr(8'h05, 32'hFFFFFFFF);
        rd_chk(8'h05, 32'h00000000);
    endtask
    task t_offset;
        for (int i = 0; i < 3; i++) begin
            wr(r_lvl, 32'hFFFFFFFC | i);
            rd_chk(r_lvl, 32'(i));
            check(warn_offset_out_q, 32'(i));
        end
        clk_en <= 1'b0;
        wr(r_lvl, 32'h00000001);
        clk_en <= 1'b1;
        rd_chk(r_lvl, 32'h00000002);
    endtask
    task t_unlock;
        for (int s = 0; s < 3; s++) begin
            pulse(0);
            wr(r_mode, 32'(s));
            rd_chk(r_mode, 32'h14 | s);
        end
        pulse(0);
        repeat (4) pulse(1);
        wr(r_mode, 32'h00000000);
        rd_chk(r_mode, 32'h00000016);
    endtask
    task t_sleep_switch;
        deep_sleep <= 1'b1;
        ticks(4);
        check(detector_mode_q, `BRW_MODE_SAMPLED);
        deep_sleep <= 1'b0;
        ticks(4);
        check(detector_mode_q, `BRW_MODE_CONT);
    endtask
    task t_warn;
        for (int t = 0; t < 3; t++) begin
            supply_below <= 1'b0;
            wr(r_ict, 32'(t * 2 + 1));
            ticks(4);
            wr(r_flg, 32'h00000001);
            supply_below <= 1'b1;
            ticks(6);
            check(warn_irq_q, t != 1);
            rd_chk(r_sta, 32'h00000001);
            rd_chk(r_flg, t != 1);
            wr(r_flg, 32'h00000000);
            rd_chk(r_flg, t != 1);
            wr(r_flg, 32'h00000001);
            supply_below <= 1'b0;
            ticks(6);
            rd_chk(r_sta, 32'h00000000);
            rd_chk(r_flg, t != 0);
        end
        wr(r_ict, 32'h00000004);
        ticks(4);
        check(warn_irq_q, 1'b0);
        rd_chk(r_flg, 32'h00000001);
    endtask
    task t_detector_off;
        pulse(0);
        wr(r_mode, 32'h00000000);
        wr(r_ict, 32'h00000001);
        wr(r_flg, 32'h00000001);
        deep_sleep <= 1'b1;
        ticks(4);
        check(monitor_enable_q, 1'b0);
        supply_below <= 1'b1;
        ticks(6);
        rd_chk(r_flg, 32'h00000000);
        supply_below <= 1'b0;
        ticks(4);
        deep_sleep <= 1'b0;
        ticks(4);
    endtask
    task t_wake_hold;
        fuse_active_mode <= `BRW_MODE_WAKE_GATED;
        pulse(2);
        rd_chk(r_mode, 32'h0000001D);
        deep_sleep <= 1'b1;
        ticks(4);
        deep_sleep <= 1'b0;
        ticks(3);
        check(exec_hold_q, 1'b1);
        ticks(12);
        check(exec_hold_q, 1'b0);
    endtask
    task automatic count_ok(input int lo, input int hi);
        int c;
        c = 0;
        pulse(2);
        ticks(4);
        repeat (160) begin
            @(negedge clock);
            if (sample_strobe_q === 1'b1)
                c++;
        end
        @(posedge clock);
        check(c >= lo && c <= hi, 1'b1);
    endtask
    task t_sample_rate;
        fuse_active_mode <= `BRW_MODE_SAMPLED;
        fuse_sample_rate <= 1'b0;
        count_ok(19, 21);
        check(detector_mode_q, `BRW_MODE_SAMPLED);
        fuse_sample_rate <= 1'b1;
        count_ok(4, 6);
    endtask
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        t_reset_regs();
        t_offset();
        t_unlock();
        t_sleep_switch();
        t_warn();
        t_detector_off();
        t_wake_hold();
        t_sample_rate();
        stop_test();
    end
endmodule // brw_top_test
`default_nettype wire
